// >>> hw/abps_sequencer.sv
// adapter qualification, battery/adapter selector with break-before-make, charge gating
// assumes analog comparators present digital levels from outside this clock domain
`timescale 1ns/1ps
module abps_sequencer
(
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // analog comparator qualifiers
    input wire logic supply_above_5v_i,
    input wire logic supply_above_undervoltage_lockout_i,
    input wire logic sense_above_0v6_i,
    input wire logic sense_above_2v4_i,
    input wire logic supply_above_battery_i,
    input wire logic adapter_above_battery_i,
    input wire logic adapter_overvoltage_i,
    input wire logic regulators_good_i,
    input wire logic thermal_shutdown_i,
    input wire logic temperature_in_window_i,
    input wire logic ratio_reference_above_2v4_i,
    input wire logic battery_below_2v9_cell_i,
    // host pins
    input wire logic charge_enable_n_i,
    input wire logic calibration_mode_i,
    input wire logic [1:0] cell_select_i,
    // switch drives and status
    output logic adapter_switch_gate_o,
    output logic battery_switch_gate_o,
    output logic adapter_valid_flag_o,
    output logic adapter_valid_flag_oe_n_o,
    output logic full_bias_o,
    output logic current_monitor_enable_o,
    output logic charge_enable_o,
    output logic [2:0] cell_count_o
);
    // ************************************************************
    // input synchronisers
    // ************************************************************
    // every comparator and host level is asynchronous to the time base, so each
    // one passes two flops before any decode reads it; the two cycles of latency
    // are nothing against the millisecond delays that follow
    localparam int NSYNC = 14; // one lane per single-bit qualifier
    logic [NSYNC-1:0] sync_a; // first stage, read only by sync_b
    logic [NSYNC-1:0] sync_b; // second stage, safe to use
    logic [1:0] cell_a; // first stage of the cell-count selection
    logic [1:0] cell_b; // second stage, feeds the cell decode
    // lane order, most significant first, matches the named taps below
    wire logic [NSYNC-1:0] raw_in = {supply_above_5v_i, supply_above_undervoltage_lockout_i, sense_above_0v6_i,
        sense_above_2v4_i, supply_above_battery_i, adapter_above_battery_i, adapter_overvoltage_i,
        regulators_good_i, thermal_shutdown_i, temperature_in_window_i, ratio_reference_above_2v4_i,
        battery_below_2v9_cell_i, charge_enable_n_i, calibration_mode_i};

    // two flops on every pin-side level
    // the cell pins reset to float, so the count starts at the two-cell default
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            sync_a <= '0;
            sync_b <= '0;
            cell_a <= abps_pkg::CELL_PIN_FLOAT;
            cell_b <= abps_pkg::CELL_PIN_FLOAT;
        end
        else
        begin
            sync_a <= raw_in;
            sync_b <= sync_a;
            cell_a <= cell_select_i;
            cell_b <= cell_a;
        end
    end

    // named synchronised qualifiers
    // the charge enable lane stays active low, as sampled
    wire logic s_sup5 = sync_b[13];
    wire logic s_undervoltage_lockout = sync_b[12];
    wire logic s_s06 = sync_b[11];
    wire logic s_s24 = sync_b[10];
    wire logic s_sup_bat = sync_b[9];
    wire logic s_ad_bat = sync_b[8];
    wire logic s_ov = sync_b[7];
    wire logic s_reg = sync_b[6];
    wire logic s_tsd = sync_b[5];
    wire logic s_tmp = sync_b[4];
    wire logic s_ref = sync_b[3];
    wire logic s_low_cell = sync_b[2];
    wire logic s_chg_n = sync_b[1];
    wire logic s_cal = sync_b[0];

    // ************************************************************
    // qualification and delays
    // ************************************************************
    // full bias only with supply valid and sense above the first level
    wire logic bias_on = s_sup5 && s_s06;
    // adapter counts as valid above the second level, only with full bias
    wire logic adapter_present = bias_on && s_s24;
    logic [abps_pkg::CNT_W-1:0] det_cnt; // time since adapter detection
    // delay end points as counter values, cut to the counter width on purpose
    localparam logic [abps_pkg::CNT_W-1:0] VALID_CNT = abps_pkg::CNT_W'(abps_pkg::VALID_DELAY_CYC);
    localparam logic [abps_pkg::CNT_W-1:0] CHANGE_CNT = abps_pkg::CNT_W'(abps_pkg::CHANGE_DELAY_CYC);
    localparam logic [abps_pkg::CNT_W-1:0] CHARGE_CNT =
        abps_pkg::CNT_W'(abps_pkg::CHANGE_DELAY_CYC + abps_pkg::OC_CHECK_CYC);
    wire logic valid_done = det_cnt >= VALID_CNT;
    wire logic change_done = det_cnt >= CHANGE_CNT;
    wire logic charge_delay_done = det_cnt >= CHARGE_CNT;

    // detection timer saturates once the charge delay is reached; restarts on loss
    // one timer serves flag release, changeover and charge, so the three stay
    // ordered against one another whatever noise the sense input carries
    // saturation keeps the counter from wrapping back under the delay marks
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            det_cnt <= '0;
        end
        else if (!adapter_present)
        begin
            det_cnt <= '0;
        end
        else if (!charge_delay_done)
        begin
            det_cnt <= det_cnt + 1'b1;
        end
    end

    // ************************************************************
    // calibration (learn) latch
    // ************************************************************
    // exit on low cell voltage holds until the host drops the mode pin, so the
    // selector does not flip back to battery while the pin stays high
    logic cal_exited;
    wire logic cal_active = s_cal && !cal_exited;
    // the pin itself still blocks charging, see the charge gate below

    // remembers the automatic exit
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            cal_exited <= 1'b0;
        end
        else if (!s_cal)
        begin
            cal_exited <= 1'b0;
        end
        else if (s_low_cell)
        begin
            cal_exited <= 1'b1;
        end
    end

    // ************************************************************
    // system power selector
    // ************************************************************
    abps_pkg::abps_sel_e sel;
    abps_pkg::abps_sel_e next_sel;
    logic [abps_pkg::CNT_W-1:0] dead_cnt; // dead time counter
    localparam logic [abps_pkg::CNT_W-1:0] DEAD_CNT = abps_pkg::CNT_W'(abps_pkg::DEAD_TIME_CYC);
    wire logic dead_done = dead_cnt >= DEAD_CNT - 1'b1;
    // go to adapter after the delay with margin, and never while calibration is active
    wire logic want_adapter = adapter_present && change_done && s_sup_bat && !cal_active;
    // leave adapter on removal only when margin is gone; calibration leaves at once
    wire logic want_battery = (!adapter_present && !s_sup_bat) || cal_active;

    // the dead-to-battery state leaves only through the counter, dead-to-adapter also on abort; they are the one road between
    // the two conducting states, so no path can close both switches at once
    // next-state decode
    always_comb
    begin
        next_sel = sel;
        case (sel)
            abps_pkg::ABPS_ON_BATTERY:
            begin
                if (want_adapter)
                begin
                    next_sel = abps_pkg::ABPS_DEAD_TO_ADAPTER;
                end
            end
            abps_pkg::ABPS_DEAD_TO_ADAPTER:
            begin
                if (!want_adapter)
                begin
                    next_sel = abps_pkg::ABPS_ON_BATTERY; // abort, back to battery
                end
                else if (dead_done)
                begin
                    next_sel = abps_pkg::ABPS_ON_ADAPTER;
                end
            end
            abps_pkg::ABPS_ON_ADAPTER:
            begin
                if (want_battery)
                begin
                    next_sel = abps_pkg::ABPS_DEAD_TO_BATTERY;
                end
            end
            abps_pkg::ABPS_DEAD_TO_BATTERY:
            begin
                if (dead_done)
                begin
                    next_sel = abps_pkg::ABPS_ON_BATTERY;
                end
            end
            // unused codes fall back to battery, the power-up selection
            default:
            begin
                next_sel = abps_pkg::ABPS_ON_BATTERY;
            end
        endcase
    end

    // dead states hold both gates off and run the dead-time counter
    wire logic in_dead = (sel == abps_pkg::ABPS_DEAD_TO_ADAPTER) || (sel == abps_pkg::ABPS_DEAD_TO_BATTERY);

    // state and dead-time counter; battery is the power-up selection
    // dead_cnt restarts on entry to each dead state and on abort
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            sel <= abps_pkg::ABPS_ON_BATTERY;
            dead_cnt <= '0;
        end
        else
        begin
            sel <= next_sel;
            dead_cnt <= (in_dead && next_sel == sel) ? dead_cnt + 1'b1 : '0;
        end
    end

    // ************************************************************
    // gate drives
    // ************************************************************
    // both off without supply; dead states hold both off
    // decoded from next_sel so each registered gate moves at the edge of the state change
    // limitation: a supply dip drops the battery gate too, and the system rides on
    // its hold-up capacitance until the supply returns
    wire logic next_ac_gate = s_sup5 && (next_sel == abps_pkg::ABPS_ON_ADAPTER) && valid_done;
    wire logic next_bat_gate = s_sup5 && (next_sel == abps_pkg::ABPS_ON_BATTERY);

    // ************************************************************
    // charge gating and status
    // ************************************************************
    // every term is a synchronised level or the delay compare, which falls only with adapter_present, so charge drops three edges after any one fails
    wire logic next_charge = !s_chg_n && s_undervoltage_lockout && adapter_present && s_ad_bat
        && !s_ov && charge_delay_done && s_reg && !s_tsd && s_tmp && s_ref && !s_cal;
    // flag released (enable high) after the valid delay; low drive otherwise
    wire logic next_flag_release = adapter_present && valid_done;
    // the unused code three is read as float and gives two cells
    logic [2:0] next_cells;
    assign next_cells = (cell_b == abps_pkg::CELL_PIN_GND) ? abps_pkg::CELLS_3 :
        (cell_b == abps_pkg::CELL_PIN_REF) ? abps_pkg::CELLS_4 : abps_pkg::CELLS_2;

    // registered outputs
    // every output is a flop so the pins never see decode glitches
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            // in reset both gates are off and the flag is pulled low
            adapter_switch_gate_o <= 1'b0;
            battery_switch_gate_o <= 1'b0;
            adapter_valid_flag_o <= 1'b0;
            adapter_valid_flag_oe_n_o <= 1'b0;
            full_bias_o <= 1'b0;
            current_monitor_enable_o <= 1'b0;
            charge_enable_o <= 1'b0;
            cell_count_o <= abps_pkg::CELLS_RESET;
        end
        else
        begin
            adapter_switch_gate_o <= next_ac_gate;
            battery_switch_gate_o <= next_bat_gate;
            adapter_valid_flag_o <= 1'b0; // open drain only ever pulls low
            adapter_valid_flag_oe_n_o <= next_flag_release;
            full_bias_o <= bias_on;
            current_monitor_enable_o <= bias_on;
            charge_enable_o <= next_charge;
            cell_count_o <= next_cells;
        end
    end
endmodule

// >>> hw/abps_pkg.sv
// timing constants, cell-count and selector state encodings for the adapter/battery path sequencer
// assumes a 250 MHz time-base clock
package abps_pkg;
    // ************************************************************
    // time base
    // ************************************************************
    localparam int CLK_MHZ = 250; // time-base clock in MHz
    localparam int VALID_DELAY_MS = 500; // adapter valid to flag release
    localparam int CHANGE_DELAY_MS = 700; // detection to changeover start
    localparam int OC_CHECK_MS = 10; // overcurrent check after the delay
    localparam int DEAD_TIME_US = 10; // both switches off
    localparam int VALID_DELAY_CYC = VALID_DELAY_MS * 1000 * CLK_MHZ;
    localparam int CHANGE_DELAY_CYC = CHANGE_DELAY_MS * 1000 * CLK_MHZ;
    localparam int OC_CHECK_CYC = OC_CHECK_MS * 1000 * CLK_MHZ;
    localparam int DEAD_TIME_CYC = DEAD_TIME_US * CLK_MHZ;
    localparam int CNT_W = 28; // wide enough for 710 ms at 250 MHz
    // ************************************************************
    // cell selection pin levels and counts
    // ************************************************************
    localparam logic [1:0] CELL_PIN_GND = 2'h0; // tied to analog ground
    localparam logic [1:0] CELL_PIN_FLOAT = 2'h1; // left floating
    localparam logic [1:0] CELL_PIN_REF = 2'h2; // tied to reference
    localparam logic [2:0] CELLS_2 = 3'h2;
    localparam logic [2:0] CELLS_3 = 3'h3;
    localparam logic [2:0] CELLS_4 = 3'h4;
    localparam logic [2:0] CELLS_RESET = 3'h2; // reset value of the count
    // ************************************************************
    // selector states
    // ************************************************************
    typedef enum logic [1:0]
    {
        ABPS_ON_BATTERY = 2'b00,
        ABPS_DEAD_TO_ADAPTER = 2'b01,
        ABPS_ON_ADAPTER = 2'b10,
        ABPS_DEAD_TO_BATTERY = 2'b11
    } abps_sel_e;
endpackage

// >>> tb/abps_monitor.sv
// checker on the adapter/battery path sequencer ports
// assumes the three-cycle qualifier-to-output latency of the sequencer
`timescale 1ns/1ps
module abps_monitor
(
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // qualifiers and host pins
    input wire logic supply_above_5v_i,
    input wire logic sense_above_0v6_i,
    input wire logic sense_above_2v4_i,
    input wire logic charge_enable_n_i,
    input wire logic calibration_mode_i,
    input wire logic [1:0] cell_select_i,
    // outputs watched
    input wire logic adapter_switch_gate_o,
    input wire logic battery_switch_gate_o,
    input wire logic adapter_valid_flag_oe_n_o,
    input wire logic full_bias_o,
    input wire logic current_monitor_enable_o,
    input wire logic charge_enable_o,
    input wire logic [2:0] cell_count_o
);
    logic armed; // low through the release edge of reset
    logic [11:0] off_cnt; // cycles with both switches off, saturating
    default clocking @(posedge clock_i); endclocking
    // the release edge still clocks the design in reset, so attempts started there are dropped
    default disable iff (reset_i || !armed);
    // ************************************************************
    // dead-time counter
    // ************************************************************
    // saturates so a long idle spell never wraps into a false short count
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
            off_cnt <= 12'h000;
        else if (adapter_switch_gate_o || battery_switch_gate_o)
            off_cnt <= 12'h000;
        else if (off_cnt != 12'hFFF)
            off_cnt <= off_cnt + 12'h001;
    end
    // arms one edge after reset falls
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
            armed <= 1'b0;
        else
            armed <= 1'b1;
    end
    // ************************************************************
    // assertions
    // ************************************************************
    both_on_a:
        assert property (!(adapter_switch_gate_o && battery_switch_gate_o)) else $error("both switches on");
    dead_time_a:
        assert property ($rose(adapter_switch_gate_o) |-> off_cnt >= 12'(abps_pkg::DEAD_TIME_CYC - 1))
        else $error("dead time too short");
    low_supply_a:
        assert property (!supply_above_5v_i |-> ##3 !adapter_switch_gate_o && !battery_switch_gate_o)
        else $error("switch on at low supply");
    cells_gnd_a:
        assert property (cell_select_i == abps_pkg::CELL_PIN_GND |-> ##3 cell_count_o == abps_pkg::CELLS_3)
        else $error("ground cell decode");
    cells_float_a:
        assert property (cell_select_i == abps_pkg::CELL_PIN_FLOAT |-> ##3 cell_count_o == abps_pkg::CELLS_2)
        else $error("float cell decode");
    cells_ref_a:
        assert property (cell_select_i == abps_pkg::CELL_PIN_REF |-> ##3 cell_count_o == abps_pkg::CELLS_4)
        else $error("reference cell decode");
    full_bias_a:
        assert property (supply_above_5v_i && sense_above_0v6_i |-> ##3 full_bias_o && current_monitor_enable_o)
        else $error("bias not up");
    monitor_low_a:
        assert property (!sense_above_0v6_i |-> ##3 !current_monitor_enable_o) else $error("monitor not held low");
    charge_pin_a:
        assert property (charge_enable_n_i |-> ##3 !charge_enable_o) else $error("charge without enable");
    charge_cal_a:
        assert property (calibration_mode_i |-> ##3 !charge_enable_o) else $error("charge in calibration");
    flag_release_a:
        assert property ($rose(adapter_valid_flag_oe_n_o) |-> $past(sense_above_2v4_i, 3))
        else $error("flag released without adapter");
    // main scenarios reached
    cover property (full_bias_o && battery_switch_gate_o);
    cover property (cell_count_o == abps_pkg::CELLS_4);
    cover property (!supply_above_5v_i ##3 !battery_switch_gate_o);
endmodule
bind abps_sequencer abps_monitor mon (.clock_i, .reset_i, .supply_above_5v_i, .sense_above_0v6_i,
    .sense_above_2v4_i, .charge_enable_n_i, .calibration_mode_i, .cell_select_i, .adapter_switch_gate_o,
    .battery_switch_gate_o, .adapter_valid_flag_oe_n_o, .full_bias_o, .current_monitor_enable_o,
    .charge_enable_o, .cell_count_o);

// >>> tb/abps_power_model.sv
// comparator front end between the analog levels and the sequencer
// assumes levels in millivolts; comparators change at any time
`timescale 1ns/1ps
module abps_power_model
(
    // analog levels
    input wire logic [15:0] supply_mv_i,
    input wire logic [15:0] sense_mv_i,
    input wire logic [15:0] bat_mv_i,
    input wire logic [2:0] cells_i,
    // comparator outputs
    output logic supply_above_5v_o,
    output logic supply_above_undervoltage_lockout_o,
    output logic sense_above_0v6_o,
    output logic sense_above_2v4_o,
    output logic supply_above_battery_o,
    output logic adapter_over_o,
    output logic regulators_good_o,
    output logic battery_low_o
);
    assign supply_above_5v_o = supply_mv_i > 16'h1388;
    assign supply_above_undervoltage_lockout_o = supply_mv_i > 16'h0FA0;
    assign sense_above_0v6_o = sense_mv_i > 16'h0258;
    assign sense_above_2v4_o = sense_mv_i > 16'h0960;
    // the divider sits before the adapter switch, so supply stands for the adapter
    assign supply_above_battery_o = supply_mv_i >= bat_mv_i + 16'h00FA;
    assign adapter_over_o = supply_mv_i > bat_mv_i + 16'h00FA;
    assign regulators_good_o = sense_above_0v6_o && supply_above_5v_o;
    assign battery_low_o = bat_mv_i < 16'(cells_i * 16'h0B54);
endmodule

// >>> tb/abps_sequencer_tb.sv
// self-checking bench for the adapter/battery path sequencer
// assumes the power model on the qualifier pins; long delays are only checked as not yet elapsed
`timescale 1ns/1ps
module abps_sequencer_tb;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic [15:0] supply_mv = 16'h0000; // input supply
    logic [15:0] sense_mv = 16'h0000; // adapter sense
    logic [15:0] bat_mv = 16'h1D4C; // battery held near 7.5 V
    logic charge_enable_n_i = 1'b1;
    logic calibration_mode_i = 1'b0;
    logic [1:0] cell_select_i = 2'h1;
    logic supply_above_5v_i, supply_above_undervoltage_lockout_i, sense_above_0v6_i, sense_above_2v4_i;
    logic supply_above_battery_i, adapter_above_battery_i, regulators_good_i, battery_below_2v9_cell_i;
    logic adapter_switch_gate_o, battery_switch_gate_o, adapter_valid_flag_o, adapter_valid_flag_oe_n_o;
    logic full_bias_o, current_monitor_enable_o, charge_enable_o;
    logic [2:0] cell_count_o;
    logic [2:0] cell_exp [4] = '{abps_pkg::CELLS_3, abps_pkg::CELLS_2, abps_pkg::CELLS_4, abps_pkg::CELLS_2};
    wire [5:0] st = {adapter_switch_gate_o, battery_switch_gate_o, full_bias_o, current_monitor_enable_o,
        charge_enable_o, adapter_valid_flag_oe_n_o};
    int errors = 0;
    int checked = 0;
    int cycles = 0;
    initial forever #2 clock_i = ~clock_i;
    abps_power_model model (.supply_mv_i(supply_mv), .sense_mv_i(sense_mv), .bat_mv_i(bat_mv),
        .cells_i(cell_count_o), .supply_above_5v_o(supply_above_5v_i), .supply_above_undervoltage_lockout_o(supply_above_undervoltage_lockout_i),
        .sense_above_0v6_o(sense_above_0v6_i), .sense_above_2v4_o(sense_above_2v4_i),
        .supply_above_battery_o(supply_above_battery_i), .adapter_over_o(adapter_above_battery_i),
        .regulators_good_o(regulators_good_i), .battery_low_o(battery_below_2v9_cell_i));
    // thermal and reference faults are tied quiet: charging never starts in a short run anyway
    abps_sequencer dut (.clock_i, .reset_i, .supply_above_5v_i, .supply_above_undervoltage_lockout_i, .sense_above_0v6_i,
        .sense_above_2v4_i, .supply_above_battery_i, .adapter_above_battery_i, .adapter_overvoltage_i(1'b0),
        .regulators_good_i, .thermal_shutdown_i(1'b0), .temperature_in_window_i(1'b1),
        .ratio_reference_above_2v4_i(1'b1), .battery_below_2v9_cell_i, .charge_enable_n_i,
        .calibration_mode_i, .cell_select_i, .adapter_switch_gate_o, .battery_switch_gate_o,
        .adapter_valid_flag_o, .adapter_valid_flag_oe_n_o, .full_bias_o, .current_monitor_enable_o,
        .charge_enable_o, .cell_count_o);
    task chk(input logic [5:0] seen, input logic [5:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task drive(input logic [15:0] s, input logic [15:0] a);
        @(posedge clock_i);
        supply_mv <= s;
        sense_mv <= a;
    endtask
    // sample after the updates of the last edge have landed
    task settle(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task end_sim();
        $display("checked=%0d errors=%0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // hang guard: the sequence needs about 1100 cycles
    always @(posedge clock_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            errors++;
            end_sim();
        end
    end
    initial
    begin
        repeat (20) @(posedge clock_i);
        reset_i <= 1'b0;
        drive(16'h2EE0, 16'h0000);
        settle(6);
        chk(st, 6'h10);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clock_i);
            cell_select_i <= 2'(i);
            settle(5);
            chk({3'h0, cell_count_o}, {3'h0, cell_exp[i]});
        end
        drive(16'h2EE0, 16'h03E8);
        settle(6);
        chk(st, 6'h1C);
        drive(16'h2EE0, 16'h0BB8);
        charge_enable_n_i <= 1'b0;
        settle(1000);
        chk(st, 6'h1C);
        @(posedge clock_i);
        calibration_mode_i <= 1'b1;
        settle(6);
        chk(st, 6'h1C);
        drive(16'h1194, 16'h0BB8);
        calibration_mode_i <= 1'b0;
        settle(6);
        chk(st, 6'h00);
        drive(16'h2EE0, 16'h0BB8);
        settle(6);
        chk(st, 6'h1C);
        @(posedge clock_i);
        reset_i <= 1'b1;
        settle(2);
        chk(st, 6'h00);
        chk({3'h0, cell_count_o}, {3'h0, abps_pkg::CELLS_RESET});
        @(posedge clock_i);
        reset_i <= 1'b0;
        settle(2);
        chk(st, 6'h00);
        settle(2);
        chk(st, 6'h1C);
        chk({5'h00, adapter_valid_flag_o}, 6'h00);
        end_sim();
    end
endmodule
